// ===== shared/wito_pkg.sv
// Constants, register map and field layout of the watchdog / interval timer.
// Assumes a 32-bit APB register bus and a single 200 MHz clock.
package wito_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices; the byte address is four times the index
    localparam logic [31:0] IDX_TIME = 32'hFFFF_F6C1;
    localparam logic [31:0] IDX_MODE = 32'hFFFF_F6C2;
    localparam logic [31:0] IDX_STATUS = 32'hFFFF_F6C3;
    localparam logic [31:0] IDX_MASK = 32'hFFFF_F6C4;

    // Register reset values
    localparam logic [7:0] RST_TIME = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;

    // Field positions of the mode/run register
    localparam int unsigned RUN_POS = 7;
    localparam int unsigned WDSEL_POS = 4;
    localparam int unsigned RSTSEL_POS = 3;
    // Period code field of the overflow-time register
    localparam int unsigned CODE_W = 3;
    localparam logic [CODE_W-1:0] CODE_LONG = 3'h7;

    // Overflow periods as powers of two of count-clock cycles
    localparam int unsigned SHIFT_BASE = 13;
    localparam int unsigned SHIFT_LONG = 21;

    // Event bits of the status and mask registers
    localparam int unsigned EV_INTERVAL = 0;
    localparam int unsigned EV_NMI = 1;
    localparam int unsigned EV_LOCKED = 2;
    localparam int unsigned EV_COUNT = 3;

    // One-hot register select
    localparam int unsigned SEL_TIME = 0;
    localparam int unsigned SEL_MODE = 1;
    localparam int unsigned SEL_STATUS = 2;
    localparam int unsigned SEL_MASK = 3;

    // Byte address of a register index
    function automatic logic [31:0] reg_addr(input logic [31:0] idx);
        reg_addr = {idx[29:0], 2'b00};
    endfunction : reg_addr

    // Address decode, shared by setup and access phases
    function automatic logic [3:0] decode_sel(input logic [31:0] addr);
        decode_sel = '0;
        decode_sel[SEL_TIME] = (addr == reg_addr(IDX_TIME));
        decode_sel[SEL_MODE] = (addr == reg_addr(IDX_MODE));
        decode_sel[SEL_STATUS] = (addr == reg_addr(IDX_STATUS));
        decode_sel[SEL_MASK] = (addr == reg_addr(IDX_MASK));
    endfunction : decode_sel

endpackage : wito_pkg

// ===== shared/wito_core_if.sv
// Carrier between the timer top, its count chain and its event flags.
// Assumes all three sit on the same clock.
`timescale 1ns/100ps
interface wito_core_if #(
    parameter int unsigned W = 21,
    parameter int unsigned N = 3
);
    // Count chain
    logic clear;
    logic enable;
    logic [2:0] code;
    logic ovf;
    logic [W-1:0] value;
    // Event flags
    logic [N-1:0] setEv;
    logic [N-1:0] clrEv;
    logic maskWr;
    logic [N-1:0] maskData;
    logic [N-1:0] status;
    logic [N-1:0] mask;
    logic irq;

    modport ctrl (output clear, enable, code, setEv, clrEv, maskWr, maskData,
                  input ovf, value, status, mask, irq);
    modport cnt (input clear, enable, code, output ovf, value);
    modport flg (input setEv, clrEv, maskWr, maskData, output status, mask, irq);
endinterface : wito_core_if

// ===== logic/wito_counter.sv
// Prescaler/counter chain with a selectable overflow tap.
// Assumes clear and enable are synchronous to ref_clk.
`timescale 1ns/100ps
module wito_counter #(
    parameter int unsigned W = 21,
    parameter int unsigned BASE_SHIFT = 13,
    parameter int unsigned LONG_SHIFT = 21
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Control side
    wito_core_if.cnt core
);
    typedef struct packed {
        logic [W-1:0] value;
        logic ovf;
    } wito_cnt_t;

    wito_cnt_t s;
    wito_cnt_t next_s;
    int unsigned shift;
    logic [W-1:0] limit;

    ////////////////////////////////////////////////////////////////////////////
    // Tap selection: codes 0..6 step by one, code 7 jumps two
    always_comb begin
        shift = (core.code == wito_pkg::CODE_LONG) ? LONG_SHIFT : BASE_SHIFT + 32'(core.code);
        limit = ~({W{1'b1}} << shift);
    end

    // Count on the main clock; >= so a shorter code mid-count still trips
    always_comb begin
        next_s = s;
        next_s.ovf = 1'b0;
        if (core.clear) begin
            next_s.value = '0;
        end else if (core.enable) begin
            if (s.value >= limit) begin
                next_s.value = '0;
                next_s.ovf = 1'b1;
            end else begin
                next_s.value = s.value + W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign core.ovf = s.ovf;
    assign core.value = s.value;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_stopped_hold: assert property (!core.enable && !core.clear |=> $stable(core.value))
        else $error("counter moved while stopped");
    chk_count_step: assert property (core.enable && !core.clear && core.value < limit
        |=> core.value == $past(core.value) + W'(1))
        else $error("counter did not step by one");
    chk_overflow_tap: assert property (core.enable && !core.clear && core.value == limit
        |=> core.ovf && core.value == '0)
        else $error("overflow not raised at selected tap");
endmodule : wito_counter

// ===== logic/wito_event_flags.sv
// Sticky event status, mask and the combined interrupt level.
// Assumes write-one-to-clear strobes last one cycle.
`timescale 1ns/100ps
module wito_event_flags #(
    parameter int unsigned N = 3
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Control side
    wito_core_if.flg core
);
    typedef struct packed {
        logic [N-1:0] status;
        logic [N-1:0] mask;
        logic irq;
    } wito_flg_t;

    wito_flg_t s;
    wito_flg_t next_s;

    ////////////////////////////////////////////////////////////////////////////
    // Set beats clear so an event in the clearing cycle is kept
    always_comb begin
        next_s = s;
        next_s.status = (s.status & ~core.clrEv) | core.setEv;
        if (core.maskWr) begin
            next_s.mask = core.maskData;
        end
        next_s.irq = |(next_s.status & next_s.mask);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign core.status = s.status;
    assign core.mask = s.mask;
    assign core.irq = s.irq;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_set_sticks: assert property (|core.setEv |=> (core.status & $past(core.setEv)) == $past(core.setEv))
        else $error("event lost in status");
    chk_irq_level: assert property (##1 core.irq == |(core.status & core.mask))
        else $error("interrupt level disagrees with status and mask");
endmodule : wito_event_flags

// ===== logic/wito_top.sv
// Watchdog / interval timer unit with APB register access.
// Assumes APB master, interrupt controller and reset logic on ref_clk.
`timescale 1ns/100ps
module wito_top #(
    parameter int unsigned BASE_SHIFT = wito_pkg::SHIFT_BASE,
    parameter int unsigned LONG_SHIFT = wito_pkg::SHIFT_LONG
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // System status
    input wire logic protectWriteEnable,
    input wire logic standbyStopIdle,
    input wire logic cpuOnSubclock,
    // Overflow outputs
    output logic maskableIntervalRequest,
    output logic nonmaskableOverflowRequest,
    output logic overflowSystemReset,
    output logic irq
);
    localparam int unsigned N = wito_pkg::EV_COUNT;
    localparam int unsigned W = LONG_SHIFT;

    typedef struct packed {
        logic [wito_pkg::CODE_W-1:0] periodCode;
        logic runBit;
        logic wdSel;
        logic rstSel;
        logic unlockArmed;
        logic [31:0] rdata;
        logic ready;
        logic slvErr;
        logic maskReq;
        logic nmiReq;
        logic sysRst;
    } wito_state_t;

    wito_state_t s;
    wito_state_t next_s;

    wito_core_if #(.W(W), .N(N)) core ();

    // Bus phase decode
    logic setupPhase;
    logic accessDone;
    logic [3:0] setupSel;
    logic [3:0] accessSel;
    logic writeDone;
    logic modeWriteOk;
    logic modeWriteLocked;
    logic runWrite;
    logic [7:0] modeView;
    logic [7:0] timeView;

    ////////////////////////////////////////////////////////////////////////////
    // Count chain and event flags
    wito_counter #(
        .W(W),
        .BASE_SHIFT(BASE_SHIFT),
        .LONG_SHIFT(LONG_SHIFT)
    ) u_counter (
        .ref_clk(ref_clk),
        .rst(rst),
        .core(core.cnt)
    );

    wito_event_flags #(
        .N(N)
    ) u_flags (
        .ref_clk(ref_clk),
        .rst(rst),
        .core(core.flg)
    );

    ////////////////////////////////////////////////////////////////////////////
    // APB phases; zero-wait answer, error flagged for unmapped addresses
    always_comb begin
        setupPhase = psel & ~penable;
        accessDone = psel & penable & s.ready;
        setupSel = wito_pkg::decode_sel(paddr);
        accessSel = wito_pkg::decode_sel(paddr);
        writeDone = accessDone & pwrite & ~s.slvErr;
        modeWriteOk = writeDone & accessSel[wito_pkg::SEL_MODE] & s.unlockArmed;
        modeWriteLocked = writeDone & accessSel[wito_pkg::SEL_MODE] & ~s.unlockArmed;
        runWrite = modeWriteOk & pwdata[wito_pkg::RUN_POS];
    end

    // Read views; unused bits read as zero
    always_comb begin
        timeView = '0;
        timeView[wito_pkg::CODE_W-1:0] = s.periodCode;
        modeView = '0;
        modeView[wito_pkg::RUN_POS] = s.runBit;
        modeView[wito_pkg::WDSEL_POS] = s.wdSel;
        modeView[wito_pkg::RSTSEL_POS] = s.rstSel;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main state update
    always_comb begin
        next_s = s;
        next_s.maskReq = 1'b0;
        next_s.nmiReq = 1'b0;
        next_s.sysRst = 1'b0;
        // Answer in the first access cycle
        next_s.ready = setupPhase;
        next_s.slvErr = setupPhase & ~(|setupSel);
        next_s.rdata = '0;
        if (setupPhase && !pwrite) begin
            unique case (1'b1)
                setupSel[wito_pkg::SEL_TIME]: begin
                    next_s.rdata = {24'h00_0000, timeView};
                end
                setupSel[wito_pkg::SEL_MODE]: begin
                    next_s.rdata = {24'h00_0000, modeView};
                end
                setupSel[wito_pkg::SEL_STATUS]: begin
                    next_s.rdata = 32'(core.status);
                end
                setupSel[wito_pkg::SEL_MASK]: begin
                    next_s.rdata = 32'(core.mask);
                end
                default: begin
                    next_s.rdata = '0;
                end
            endcase
        end
        // Overflow time select: plain read/write
        if (writeDone && accessSel[wito_pkg::SEL_TIME]) begin
            next_s.periodCode = pwdata[wito_pkg::CODE_W-1:0];
        end
        // Protected register: bits only ever set by software
        if (modeWriteOk) begin
            next_s.runBit = s.runBit | pwdata[wito_pkg::RUN_POS];
            next_s.wdSel = s.wdSel | pwdata[wito_pkg::WDSEL_POS];
            next_s.rstSel = s.rstSel | pwdata[wito_pkg::RSTSEL_POS];
        end
        // Unlock is spent by any write; a new pulse wins the same cycle
        if (accessDone && pwrite) begin
            next_s.unlockArmed = 1'b0;
        end
        if (protectWriteEnable) begin
            next_s.unlockArmed = 1'b1;
        end
        // Route each overflow by mode
        if (core.ovf) begin
            if (!s.wdSel) begin
                next_s.maskReq = 1'b1;
            end else if (!s.rstSel) begin
                next_s.nmiReq = 1'b1;
            end else begin
                next_s.sysRst = 1'b1;
            end
        end
    end

    // Reset returns both registers to zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Count chain control; pauses hold the value rather than clear it
    assign core.clear = runWrite;
    assign core.enable = s.runBit & ~standbyStopIdle & ~cpuOnSubclock;
    assign core.code = s.periodCode;

    // Events into the sticky flags; status is write-one-to-clear
    always_comb begin
        core.setEv = '0;
        core.setEv[wito_pkg::EV_INTERVAL] = core.ovf & ~s.wdSel;
        core.setEv[wito_pkg::EV_NMI] = core.ovf & s.wdSel;
        core.setEv[wito_pkg::EV_LOCKED] = modeWriteLocked;
        core.clrEv = (writeDone && accessSel[wito_pkg::SEL_STATUS]) ? pwdata[N-1:0] : '0;
        core.maskWr = writeDone & accessSel[wito_pkg::SEL_MASK];
        core.maskData = pwdata[N-1:0];
    end

    // Outputs straight from flip-flops
    assign prdata = s.rdata;
    assign pready = s.ready;
    assign pslverr = s.slvErr;
    assign maskableIntervalRequest = s.maskReq;
    assign nonmaskableOverflowRequest = s.nmiReq;
    assign overflowSystemReset = s.sysRst;
    assign irq = core.irq;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence seqUnlockedRun;
        psel && penable && pready && pwrite && s.unlockArmed && !pslverr
            && paddr == wito_pkg::reg_addr(wito_pkg::IDX_MODE) && pwdata[wito_pkg::RUN_POS];
    endsequence

    sequence seqCountRestart;
        ##1 s.runBit && core.value == '0;
    endsequence

    sequence seqLockedWrite;
        psel && penable && pready && pwrite && !s.unlockArmed && !pslverr
            && paddr == wito_pkg::reg_addr(wito_pkg::IDX_MODE);
    endsequence

    property propRestart;
        seqUnlockedRun |-> seqCountRestart;
    endproperty

    property propLocked;
        seqLockedWrite |=> $stable(modeView);
    endproperty

    chk_mask_on_ovf: assert property (core.ovf && !s.wdSel
        |=> maskableIntervalRequest && !nonmaskableOverflowRequest && !overflowSystemReset)
        else $error("interval overflow did not raise maskable request");
    chk_nmi_on_ovf: assert property (core.ovf && s.wdSel && !s.rstSel
        |=> nonmaskableOverflowRequest && !maskableIntervalRequest && !overflowSystemReset)
        else $error("watchdog overflow did not raise non-maskable request");
    chk_reset_on_ovf: assert property (core.ovf && s.wdSel && s.rstSel
        |=> overflowSystemReset && !maskableIntervalRequest && !nonmaskableOverflowRequest)
        else $error("watchdog overflow did not raise system reset");
    chk_no_spurious_req: assert property (!core.ovf
        |=> !maskableIntervalRequest && !nonmaskableOverflowRequest && !overflowSystemReset)
        else $error("overflow output without overflow");
    chk_run_sticky: assert property (s.runBit |=> s.runBit)
        else $error("run bit cleared without reset");
    chk_mode_sticky: assert property (s.wdSel || s.rstSel
        |=> (s.wdSel >= $past(s.wdSel)) && (s.rstSel >= $past(s.rstSel)))
        else $error("mode select bit cleared without reset");
    chk_locked_write: assert property (propLocked)
        else $error("unprotected write changed mode register");
    chk_run_restart: assert property (propRestart)
        else $error("run write did not clear and start the count");
    chk_reserved_zero: assert property (pready && !pwrite && !pslverr
        && paddr == wito_pkg::reg_addr(wito_pkg::IDX_TIME) |-> prdata[7:wito_pkg::CODE_W] == '0)
        else $error("reserved time register bits read non-zero");
    chk_standby_hold: assert property ((standbyStopIdle || cpuOnSubclock) && !core.clear
        |=> $stable(core.value))
        else $error("count moved in standby or on subclock");
    chk_reset_values: assert property ($fell(rst) |-> s.periodCode == '0 && !s.runBit
        && !s.wdSel && !s.rstSel)
        else $error("registers not zero after reset");
    chk_unlock_single: assert property (accessDone && pwrite && !protectWriteEnable |=> !s.unlockArmed)
        else $error("unlock survived a write");
    chk_apb_answer: assert property (psel && !penable |=> pready)
        else $error("no answer in first access cycle");
endmodule : wito_top

// ===== tb/wito_sys_model.sv
// Partner: protection unlock pulse and overflow request counters.
// Assumes one-cycle request pulses from the timer on ref_clk.
`timescale 1ns/100ps
module wito_sys_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Bench request for one protected write
    input wire logic unlockReq,
    // Timer requests and unlock pulse
    input wire logic nonmaskableOverflowRequest,
    input wire logic overflowSystemReset,
    output logic protectWriteEnable,
    output int nmiSeen,
    output int resetSeen
);
    ////////////////////////////////////////////////////////////
    // Single-use pulse; low in reset so no stale unlock survives
    always @(posedge ref_clk) begin
        protectWriteEnable <= unlockReq && !rst;
        if (rst) begin
            nmiSeen <= 0;
            resetSeen <= 0;
        end else begin
            nmiSeen <= nmiSeen + int'(nonmaskableOverflowRequest);
            resetSeen <= resetSeen + int'(overflowSystemReset);
        end
    end
endmodule : wito_sys_model

// ===== tb/wito_top_tb.sv
// Self-checking bench of the watchdog / interval timer with a register model.
// Assumes the partner supplies unlock pulses and counts overflow requests.
`timescale 1ns/100ps
module wito_top_tb;
    // Short overflow periods keep the run brief
    localparam int BS = 3;
    localparam int LS = 10;
    localparam logic [31:0] A_TIME = wito_pkg::IDX_TIME << 2;
    localparam logic [31:0] A_MODE = wito_pkg::IDX_MODE << 2;
    localparam logic [31:0] A_STAT = wito_pkg::IDX_STATUS << 2;
    localparam logic [31:0] A_MASK = wito_pkg::IDX_MASK << 2;
    logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, errq, irq;
    logic standbyStopIdle, cpuOnSubclock, unlockReq, protectWriteEnable, mir, nmr, osr;
    logic [31:0] paddr, pwdata, prdata, rdq, rnd;
    int nmiSeen, resetSeen, err_count, checks_done, mdlTime, mdlMode, n;

    ////////////////////////////////////////////////////////////
    wito_top #(.BASE_SHIFT(BS), .LONG_SHIFT(LS)) uut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .protectWriteEnable(protectWriteEnable),
        .standbyStopIdle(standbyStopIdle), .cpuOnSubclock(cpuOnSubclock),
        .maskableIntervalRequest(mir), .nonmaskableOverflowRequest(nmr),
        .overflowSystemReset(osr), .irq(irq));
    wito_sys_model partner (.ref_clk(ref_clk), .rst(rst), .unlockReq(unlockReq),
        .nonmaskableOverflowRequest(nmr), .overflowSystemReset(osr),
        .protectWriteEnable(protectWriteEnable), .nmiSeen(nmiSeen), .resetSeen(resetSeen));

    // 200 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    // Model period in clock cycles for a period code
    function automatic int per(input int c);
        return 1 << ((c == 7) ? LS : BS + c);
    endfunction : per

    function automatic logic pick(input int k);
        return (k == 0) ? mir : ((k == 1) ? nmr : osr);
    endfunction : pick

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; request held until pready is seen at an edge
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        rdq = prdata;
        errq = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (t >= 50) err_count++;
    endtask : xfer

    // Write with optional unlock; select and run bits only ever set
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic unl);
        if (unl) begin
            unlockReq <= 1'b1;
            @(posedge ref_clk);
            unlockReq <= 1'b0;
            @(posedge ref_clk);
        end
        if (a == A_TIME) mdlTime = d & 8'h07;
        if (a == A_MODE && unl) mdlMode = mdlMode | (d & 8'h98);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        check(rdq, exp);
        check(errq, 1'b0);
    endtask : rd

    // Sync on a pulse, then count cycles to the next with an optional pause
    task automatic period(input int k, input int hold, input logic sub, output int cnt);
        int t;
        t = 0;
        while (pick(k) !== 1'b1 && t < 2000) begin
            @(posedge ref_clk);
            t++;
        end
        cnt = 0;
        do begin
            standbyStopIdle <= (cnt < hold) && !sub;
            cpuOnSubclock <= (cnt < hold) && sub; // No register access meanwhile
            @(posedge ref_clk);
            cnt++;
        end while (pick(k) !== 1'b1 && cnt < 2000);
    endtask : period

    task automatic do_reset();
        rst <= 1'b1;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        mdlTime = 0;
        mdlMode = 0;
    endtask : do_reset

    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////
    // Watchdog on the whole run, a hang counts as a mismatch
    initial begin
        repeat (60000) @(posedge ref_clk);
        err_count++;
        final_report();
    end

    // Main sequence
    initial begin
        {psel, penable, pwrite, standbyStopIdle, cpuOnSubclock, unlockReq} = 6'h00;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
        rst = 1'b1;
        err_count = 0;
        checks_done = 0;
        rnd = 32'h0000_92BF;
        do_reset();
        rd(A_TIME, 8'h00);
        rd(A_MODE, 8'h00);
        rnd = xs(rnd);
        wr(A_TIME, rnd, 1'b0);
        rd(A_TIME, mdlTime);
        rnd = xs(rnd);
        xfer(1'b0, A_MASK + {24'h00_0000, rnd[7:4], 4'h4}, 32'h0000_0000);
        check(rdq, 8'h00);
        check(errq, 1'b1);
        // Unlocked-less write refused and flagged; masked, enabled, cleared
        wr(A_MASK, 8'h03, 1'b0);
        wr(A_MODE, 8'h98, 1'b0);
        rd(A_MODE, mdlMode);
        rd(A_STAT, 8'h04);
        check(irq, 1'b0);
        wr(A_MASK, 8'h07, 1'b0);
        // Level is launched at the write edge; look one edge later
        @(posedge ref_clk);
        check(irq, 1'b1);
        wr(A_STAT, 8'h04, 1'b0);
        rd(A_STAT, 8'h00);
        check(irq, 1'b0);
        // Interval mode at every period code, restarting each overflow
        wr(A_MODE, 8'h88, 1'b1);
        rd(A_MODE, mdlMode);
        for (int c = 0; c < 8; c++) begin
            rnd = xs(rnd);
            wr(A_TIME, {rnd[31:3], c[2:0]}, 1'b0);
            period(0, 0, 1'b0, n);
            check(n, per(c));
        end
        check(irq, 1'b1);
        check(nmiSeen, 0);
        check(resetSeen, 0);
        // Run cannot be cleared; pauses hold the count
        wr(A_MODE, 8'h00, 1'b1);
        period(0, 0, 1'b0, n);
        check(n, per(7));
        rd(A_MODE, mdlMode);
        wr(A_TIME, 8'h00, 1'b0);
        period(0, 5, 1'b0, n);
        check(n, per(0) + 5);
        period(0, 6, 1'b1, n);
        check(n, per(0) + 6);
        // Watchdog with non-maskable request, sticky selects, kicks
        do_reset();
        wr(A_MODE, 8'h90, 1'b1);
        period(1, 0, 1'b0, n);
        check(n, per(0));
        rd(A_STAT, 8'h02);
        wr(A_MODE, 8'h00, 1'b1);
        rd(A_MODE, mdlMode);
        repeat (2) wr(A_MODE, 8'h90, 1'b1);
        n = nmiSeen;
        repeat (20) wr(A_MODE, 8'h90, 1'b1);
        check(nmiSeen, n);
        // Reset pattern drives the system reset request only
        do_reset();
        wr(A_MODE, 8'h98, 1'b1);
        period(2, 0, 1'b0, n);
        check(n, per(0));
        check(nmiSeen, 0);
        check(resetSeen > 0, 1'b1);
        rd(A_MODE, mdlMode);
        final_report();
    end
endmodule : wito_top_tb
